// ==== verilog/alu_slice16.sv ====
`timescale 1ns/1ns

module alu_slice16
(
   input  wire logic                         CLK_SYS,           // System clock, 100 MHz.
   input  wire logic                         RESET,             // Synchronous reset, high.
   input  wire logic [alu_pkg::WORD_W-1:0]   A_IN,              // Operand A.
   input  wire logic [alu_pkg::WORD_W-1:0]   B_IN,              // Operand B.
   input  wire logic                         CARRY_IN,          // Carry into bit 0.
   input  wire logic [alu_pkg::FSEL_W-1:0]   FUNCTION_SELECT,   // ALU function code.
   input  wire logic                         EN_A_N,            // A register load, low.
   input  wire logic                         EN_B_N,            // B register load, low.
   input  wire logic                         EN_F_N,            // Result register load, low.
   input  wire logic                         OPERAND_BYPASS,    // Bypass A and B registers.
   input  wire logic                         RESULT_BYPASS,     // Bypass result register.
   input  wire logic                         A_OPERAND_SELECT,  // A operand select.
   input  wire logic                         B_OPERAND_SELECT,  // B operand select.
   input  wire logic                         OE_N,              // Result drive enable, low.
   output logic      [alu_pkg::WORD_W-1:0]   F_OUT,             // Result word.
   output logic                              F_OE_N,            // Result pin enable, low.
   output logic                              CARRY_OUT,         // Carry out of bit 15.
   output logic                              PROPAGATE_N,       // Group propagate, low.
   output logic                              GENERATE_N,        // Group generate, low.
   output logic                              OVERFLOW_FLAG,     // Arithmetic overflow.
   output logic                              ZERO_FLAG,         // Result is zero.
   input  wire logic                         HSEL,              // AHB slave select.
   input  wire logic [31:0]                  HADDR,             // AHB address.
   input  wire logic [1:0]                   HTRANS,            // AHB transfer type.
   input  wire logic                         HWRITE,            // AHB write.
   input  wire logic [2:0]                   HSIZE,             // AHB size, word only.
   input  wire logic [31:0]                  HWDATA,            // AHB write data.
   input  wire logic                         HREADY,            // AHB bus ready.
   output logic      [31:0]                  HRDATA,            // AHB read data.
   output logic                              HREADYOUT,         // AHB slave ready.
   output logic                              HRESP,             // AHB response, OKAY.
   output logic                              IRQ                // Interrupt, high.
);

   // =====================================================================
   // Declarations.
   // =====================================================================
   logic [alu_pkg::WORD_W-1:0] a_q;
   logic [alu_pkg::WORD_W-1:0] a_d;
   logic [alu_pkg::WORD_W-1:0] b_q;
   logic [alu_pkg::WORD_W-1:0] b_d;
   logic [alu_pkg::WORD_W-1:0] f_q;
   logic [alu_pkg::WORD_W-1:0] f_d;
   logic [alu_pkg::WORD_W-1:0] a_src;
   logic [alu_pkg::WORD_W-1:0] b_src;
   logic [alu_pkg::WORD_W-1:0] alu_a;
   logic [alu_pkg::WORD_W-1:0] alu_b;
   logic [alu_pkg::WORD_W-1:0] term_a;
   logic [alu_pkg::WORD_W-1:0] term_b;
   logic [alu_pkg::WORD_W-1:0] bit_g;
   logic [alu_pkg::WORD_W-1:0] bit_p;
   logic [alu_pkg::WORD_W-1:0] grp_g;
   logic [alu_pkg::WORD_W-1:0] grp_p;
   logic [alu_pkg::WORD_W-1:0] carry;
   logic [alu_pkg::WORD_W-1:0] sum;
   logic [alu_pkg::WORD_W-1:0] alu_f;
   logic                       carry16;
   logic                       is_arith;
   alu_pkg::alu_func_e         func;
   alu_pkg::alu_status_s       stat;

   alu_pkg::alu_ahb_phase_s    aph_q;
   alu_pkg::alu_ahb_phase_s    aph_d;
   logic [31:0]                rdata_q;
   logic [31:0]                rdata_d;
   logic [alu_pkg::EVT_W-1:0]  evt_q;
   logic [alu_pkg::EVT_W-1:0]  evt_d;
   logic [alu_pkg::EVT_W-1:0]  mask_q;
   logic [alu_pkg::EVT_W-1:0]  mask_d;
   logic [alu_pkg::EVT_W-1:0]  evt_set;
   logic                       addr_take;

   assign func = alu_pkg::alu_func_e'(FUNCTION_SELECT);

   // =====================================================================
   // Pipeline registers.
   // =====================================================================

   // Operand registers keep loading even while bypassed, so releasing the
   // bypass shows whatever was last captured.
   always_comb
   begin
      a_d = EN_A_N ? a_q : A_IN;
      b_d = EN_B_N ? b_q : B_IN;
      f_d = EN_F_N ? f_q : alu_f;
   end

   // No reset on the datapath: a real slice powers up with random contents,
   // and resetting sixteen-bit words would only cost area.
   always_ff @(posedge CLK_SYS)
   begin
      a_q <= a_d;
      b_q <= b_d;
      f_q <= f_d;
   end

   // =====================================================================
   // Operand selection.
   // =====================================================================

   // Bypass picks the raw inputs, then the operand mux may force a zero or
   // take the registered result back; feedback never follows the bypass.
   always_comb
   begin
      a_src = OPERAND_BYPASS ? A_IN : a_q;
      b_src = OPERAND_BYPASS ? B_IN : b_q;
      if (!B_OPERAND_SELECT && !A_OPERAND_SELECT)
      begin
         alu_b = f_q;
         alu_a = a_src;
      end
      else if (!B_OPERAND_SELECT && A_OPERAND_SELECT)
      begin
         alu_b = '0;
         alu_a = a_src;
      end
      else if (B_OPERAND_SELECT && !A_OPERAND_SELECT)
      begin
         alu_b = b_src;
         alu_a = '0;
      end
      else
      begin
         alu_b = b_src;
         alu_a = a_src;
      end
   end

   // =====================================================================
   // Arithmetic core.
   // =====================================================================

   // The terms feed both the sum and the cascade outputs, so the adder and
   // the status are always consistent with each other.
   always_comb
   begin
      term_a = alu_a;
      term_b = alu_b;
      if (func == alu_pkg::FN_NOTA_B)
      begin
         term_a = ~alu_a;
      end
      else if (func == alu_pkg::FN_A_NOTB)
      begin
         term_b = ~alu_b;
      end
      bit_g = term_a & term_b;
      bit_p = term_a | term_b;
      grp_g[0] = bit_g[0];
      grp_p[0] = bit_p[0];
      carry[0] = CARRY_IN;
      for (int i = 1; i < alu_pkg::WORD_W; i++)
      begin
         grp_p[i] = bit_p[i] & grp_p[i-1];
         grp_g[i] = bit_g[i] | (bit_p[i] & grp_g[i-1]);
         carry[i] = grp_g[i-1] | (grp_p[i-1] & carry[i-1]);
      end
      carry16 = grp_g[alu_pkg::WORD_W-1]
              | (grp_p[alu_pkg::WORD_W-1] & carry[alu_pkg::WORD_W-1]);
      sum = term_a ^ term_b ^ carry;
   end

   // =====================================================================
   // Function select.
   // =====================================================================

   // Logical and fill codes bypass the adder; the three arithmetic codes
   // all share the same sum path with the operand inversions above.
   always_comb
   begin
      is_arith = 1'b0;
      case (func)
         alu_pkg::FN_CLEAR:  alu_f = '0;
         alu_pkg::FN_NOTA_B,
         alu_pkg::FN_A_NOTB,
         alu_pkg::FN_A_PLUS:
         begin
            alu_f    = sum;
            is_arith = 1'b1;
         end
         alu_pkg::FN_XOR:    alu_f = alu_a ^ alu_b;
         alu_pkg::FN_OR:     alu_f = alu_a | alu_b;
         alu_pkg::FN_AND:    alu_f = alu_a & alu_b;
         default:            alu_f = '1;
      endcase
   end

   // Cascade outputs follow the adder terms for every code; outside the
   // arithmetic codes they carry no meaning and users must ignore them.
   always_comb
   begin
      stat.propagate_n = ~grp_p[alu_pkg::WORD_W-1];
      stat.generate_n  = ~grp_g[alu_pkg::WORD_W-1];
      stat.carry_out   = carry16;
      stat.overflow    = carry[alu_pkg::WORD_W-1] ^ carry16;
      stat.zero        = (alu_f == '0);
   end

   // Pin drivers; the result pin enable simply mirrors the drive request.
   assign F_OUT         = RESULT_BYPASS ? alu_f : f_q;
   assign F_OE_N        = OE_N;
   assign CARRY_OUT     = stat.carry_out;
   assign PROPAGATE_N   = stat.propagate_n;
   assign GENERATE_N    = stat.generate_n;
   assign OVERFLOW_FLAG = stat.overflow;
   assign ZERO_FLAG     = stat.zero;

   // =====================================================================
   // Event capture and interrupt.
   // =====================================================================

   // Events are logged when the result register loads, so each captured
   // word raises its flags once; carry and overflow only for arithmetic.
   always_comb
   begin
      evt_set = '0;
      if (!EN_F_N)
      begin
         evt_set[alu_pkg::EVT_OVF_BIT]   = is_arith & stat.overflow;
         evt_set[alu_pkg::EVT_CARRY_BIT] = is_arith & stat.carry_out;
         evt_set[alu_pkg::EVT_ZERO_BIT]  = stat.zero;
      end
   end

   // =====================================================================
   // AHB-Lite slave.
   // =====================================================================

   // Zero wait states: the address phase is captured, read data is fetched
   // at that edge and writes land at the end of the data phase.
   assign addr_take = HSEL & HREADY & HTRANS[alu_pkg::HTRANS_ACTIVE_BIT];

   always_comb
   begin
      aph_d.valid = addr_take;
      aph_d.write = HWRITE;
      aph_d.addr  = HADDR & alu_pkg::ADDR_MASK;
      rdata_d     = rdata_q;
      mask_d      = mask_q;
      // Set wins over a write-one clear in the same cycle.
      evt_d       = evt_q;
      if (aph_q.valid && aph_q.write)
      begin
         if (aph_q.addr == alu_pkg::EVT_STATUS_OFS)
         begin
            evt_d = evt_q & ~HWDATA[alu_pkg::EVT_W-1:0];
         end
         else if (aph_q.addr == alu_pkg::EVT_MASK_OFS)
         begin
            mask_d = HWDATA[alu_pkg::EVT_W-1:0];
         end
      end
      evt_d = evt_d | evt_set;
      if (addr_take && !HWRITE)
      begin
         rdata_d = '0;
         if ((HADDR & alu_pkg::ADDR_MASK) == alu_pkg::EVT_STATUS_OFS)
         begin
            rdata_d[alu_pkg::EVT_W-1:0] = evt_q;
         end
         else if ((HADDR & alu_pkg::ADDR_MASK) == alu_pkg::EVT_MASK_OFS)
         begin
            rdata_d[alu_pkg::EVT_W-1:0] = mask_q;
         end
         else if ((HADDR & alu_pkg::ADDR_MASK) == alu_pkg::RESULT_OFS)
         begin
            rdata_d[alu_pkg::RES_WORD_LSB +: alu_pkg::WORD_W] = f_q;
            rdata_d[alu_pkg::RES_FLAG_LSB +: 5]               = stat;
         end
      end
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (RESET)
      begin
         aph_q   <= '0;
         rdata_q <= '0;
         evt_q   <= alu_pkg::EVT_RESET;
         mask_q  <= alu_pkg::MASK_RESET;
      end
      else
      begin
         aph_q   <= aph_d;
         rdata_q <= rdata_d;
         evt_q   <= evt_d;
         mask_q  <= mask_d;
      end
   end

   // Only word transfers are meaningful; other sizes behave as words.
   assign HRDATA    = rdata_q;
   assign HREADYOUT = 1'b1;
   assign HRESP     = 1'b0;
   assign IRQ       = |(evt_q & mask_q);

endmodule : alu_slice16

// ==== verilog/alu_pkg.sv ====
package alu_pkg;

   // =====================================================================
   // Widths and function select encodings.
   // =====================================================================
   localparam int unsigned WORD_W = 16;
   localparam int unsigned FSEL_W = 3;

   typedef enum logic [2:0]
   {
      FN_CLEAR   = 3'h0,
      FN_NOTA_B  = 3'h1,
      FN_A_NOTB  = 3'h2,
      FN_A_PLUS  = 3'h3,
      FN_XOR     = 3'h4,
      FN_OR      = 3'h5,
      FN_AND     = 3'h6,
      FN_PRESET  = 3'h7
   } alu_func_e;

   // =====================================================================
   // Register map of the bus slave, byte addresses of aligned words.
   // =====================================================================
   localparam logic [31:0] EVT_STATUS_OFS = 32'h0000_0000;
   localparam logic [31:0] EVT_MASK_OFS   = 32'h0000_0004;
   localparam logic [31:0] RESULT_OFS     = 32'h0000_0008;
   localparam logic [31:0] ADDR_MASK      = 32'h0000_00ff;

   // Event bit positions, shared by the status and mask registers.
   localparam int unsigned EVT_OVF_BIT   = 0;
   localparam int unsigned EVT_CARRY_BIT = 1;
   localparam int unsigned EVT_ZERO_BIT  = 2;
   localparam int unsigned EVT_W         = 3;

   // Result register readback layout: result word, then live flags.
   localparam int unsigned RES_WORD_LSB = 0;
   localparam int unsigned RES_FLAG_LSB = 16;

   localparam logic [EVT_W-1:0] EVT_RESET  = 3'h0;
   localparam logic [EVT_W-1:0] MASK_RESET = 3'h0;

   // AHB transfer type bit that marks an active transfer.
   localparam int unsigned HTRANS_ACTIVE_BIT = 1;

   // =====================================================================
   // Carrier structures.
   // =====================================================================
   typedef struct packed
   {
      logic overflow;
      logic zero;
      logic carry_out;
      logic propagate_n;
      logic generate_n;
   } alu_status_s;

   typedef struct packed
   {
      logic        valid;
      logic        write;
      logic [31:0] addr;
   } alu_ahb_phase_s;

endpackage : alu_pkg

// ==== tb/alu_ctl_model.sv ====
`timescale 1ns/1ns
// =====================================================================
// Controller model: it owns the operand and control pins of the slice.
// =====================================================================
module alu_ctl_model
(
   input  wire logic        clk,   // System clock.
   output logic      [15:0] a_o,   // Operand A pins.
   output logic      [15:0] b_o,   // Operand B pins.
   output logic      [11:0] ctl_o  // Carry, code, enables, bypasses, selects, drive.
);
   // Start idle with defined data fed straight through, so no flag is unknown.
   initial
   begin
      a_o = 16'h0;
      b_o = 16'h0;
      ctl_o = 12'h0ff;
   end

   // New values land just after an edge and stand for a whole cycle.
   task automatic drive(input logic [15:0] a, b, input logic [11:0] c);
      @(posedge clk);
      a_o <= a;
      b_o <= b;
      ctl_o <= c;
   endtask : drive

   // A difference needs carry in high together with an inverting code.
   task automatic sub(input logic [15:0] a, b, input logic a_minus_b);
      drive(a, b, {1'b1, a_minus_b ? 3'h2 : 3'h1, 8'hfe});
   endtask : sub
endmodule : alu_ctl_model

// ==== tb/alu_monitor.sv ====
`timescale 1ns/1ns
// =====================================================================
// Port checker for the ALU slice.
// =====================================================================
module alu_monitor
(
   input wire logic        CLK_SYS,          // Clock.
   input wire logic        RESET,            // Reset.
   input wire logic [15:0] A_IN,             // Operand A.
   input wire logic [15:0] B_IN,             // Operand B.
   input wire logic        CARRY_IN,         // Carry in.
   input wire logic [2:0]  FUNCTION_SELECT,  // Code.
   input wire logic        EN_F_N,           // Result load.
   input wire logic        OPERAND_BYPASS,   // Operand bypass.
   input wire logic        RESULT_BYPASS,    // Result bypass.
   input wire logic        A_OPERAND_SELECT, // A select.
   input wire logic        B_OPERAND_SELECT, // B select.
   input wire logic        OE_N,             // Drive request.
   input wire logic [15:0] F_OUT,            // Result.
   input wire logic        F_OE_N,           // Pin enable.
   input wire logic        CARRY_OUT,        // Carry out.
   input wire logic        PROPAGATE_N,      // Propagate.
   input wire logic        GENERATE_N,       // Generate.
   input wire logic        OVERFLOW_FLAG,    // Overflow.
   input wire logic        ZERO_FLAG         // Zero.
);
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (RESET);

   // Reference sums, only trusted while a plain add sees the pins directly.
   logic        add_on;
   logic [16:0] gsum;
   logic [16:0] sum;
   assign add_on = OPERAND_BYPASS && A_OPERAND_SELECT && B_OPERAND_SELECT
                   && FUNCTION_SELECT == 3'h3;
   assign gsum = {1'b0, A_IN} + {1'b0, B_IN};
   assign sum = gsum + {16'h0, CARRY_IN};

   sequence s_load;
      RESULT_BYPASS && !EN_F_N;
   endsequence
   property p_zero; RESULT_BYPASS |-> ZERO_FLAG == (F_OUT == 16'h0); endproperty
   property p_fadd; add_on && RESULT_BYPASS |-> F_OUT == sum[15:0]; endproperty
   property p_pn; add_on |-> PROPAGATE_N == !(&(A_IN | B_IN)); endproperty
   property p_gn; add_on |-> GENERATE_N == !gsum[16]; endproperty
   property p_cout; add_on |-> CARRY_OUT == sum[16]; endproperty
   property p_ovf;
      add_on |-> OVERFLOW_FLAG == (sum[16] ^ sum[15] ^ A_IN[15] ^ B_IN[15]);
   endproperty
   property p_oe; F_OE_N == OE_N; endproperty
   property p_hold; !RESULT_BYPASS && $past(!RESULT_BYPASS) && $past(EN_F_N) |-> $stable(F_OUT);
   endproperty
   property p_load; s_load ##1 !RESULT_BYPASS |-> F_OUT == $past(F_OUT); endproperty

   a_zero: assert property (p_zero) else $error("zero flag wrong");
   a_fadd: assert property (p_fadd) else $error("sum wrong");
   a_pn: assert property (p_pn) else $error("propagate wrong");
   a_gn: assert property (p_gn) else $error("generate wrong");
   a_cout: assert property (p_cout) else $error("carry out wrong");
   a_ovf: assert property (p_ovf) else $error("overflow wrong");
   a_oe: assert property (p_oe) else $error("pin enable wrong");
   a_hold: assert property (p_hold) else $error("result moved");
   a_load: assert property (p_load) else $error("result not held");
endmodule : alu_monitor

// ==== tb/tb.sv ====
`timescale 1ns/1ns
module tb;
   // =====================================================================
   // Pins, counters and the device.
   // =====================================================================
   logic        clk_sys = 1'b0;
   logic        reset = 1'b1;
   logic [15:0] a_in, b_in, f_out;
   logic [11:0] ctl;
   logic        f_oe_n, c_out, p_n, g_n, ovf, zero, hrdy, hresp, irq;
   logic        hsel = 1'b0, hwrite = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, d;
   logic [20:0] obs;
   int          miscompares = 0;
   int          samples_checked = 0;

   // Live flags and result in the readback layout.
   assign obs = {ovf, zero, c_out, p_n, g_n, f_out};
   always #5 clk_sys = ~clk_sys;

   alu_ctl_model cm (.clk(clk_sys), .a_o(a_in), .b_o(b_in), .ctl_o(ctl));
   alu_slice16 uut
   (
      .CLK_SYS(clk_sys), .RESET(reset), .A_IN(a_in), .B_IN(b_in),
      .CARRY_IN(ctl[11]), .FUNCTION_SELECT(ctl[10:8]), .EN_A_N(ctl[7]),
      .EN_B_N(ctl[6]), .EN_F_N(ctl[5]), .OPERAND_BYPASS(ctl[4]),
      .RESULT_BYPASS(ctl[3]), .A_OPERAND_SELECT(ctl[2]), .B_OPERAND_SELECT(ctl[1]),
      .OE_N(ctl[0]), .F_OUT(f_out), .F_OE_N(f_oe_n), .CARRY_OUT(c_out),
      .PROPAGATE_N(p_n), .GENERATE_N(g_n), .OVERFLOW_FLAG(ovf), .ZERO_FLAG(zero),
      .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
      .HWDATA(hwdata), .HREADY(hrdy), .HRDATA(hrdata), .HREADYOUT(hrdy),
      .HRESP(hresp), .IRQ(irq)
   );

   task automatic chk(input string nm, input logic [31:0] got, exp);
      samples_checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // Expected {overflow, zero, carry, propagate_n, generate_n, result}.
   function automatic logic [20:0] ref_alu(input logic [15:0] a, b, input logic c,
                                           input logic [2:0] f);
      logic [15:0] x, y, r;
      logic [16:0] g, s;
      x = (f == 3'h1) ? ~a : a;
      y = (f == 3'h2) ? ~b : b;
      g = {1'b0, x} + {1'b0, y};
      s = g + {16'h0, c};
      case (f)
         3'h0: r = 16'h0;
         3'h4: r = a ^ b;
         3'h5: r = a | b;
         3'h6: r = a & b;
         3'h7: r = 16'hffff;
         default: r = s[15:0];
      endcase
      return {s[16] ^ s[15] ^ x[15] ^ y[15], r == 16'h0, s[16], ~&(x | y), ~g[16], r};
   endfunction : ref_alu

   // One word transfer; each phase stands until hready is seen high.
   // The master counts no cycles itself: only the watchdog ends a wait.
   task automatic bus(input logic w, input logic [31:0] ad, wd, output logic [31:0] rd);
      @(posedge clk_sys);
      hsel <= 1'b1;
      haddr <= ad;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge clk_sys); while (hrdy !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk_sys); while (hrdy !== 1'b1);
      rd = hrdata;
      chk("hresp", 32'(hresp), 32'h0);
   endtask : bus

   task automatic rd_chk(input string nm, input logic [31:0] ad, exp);
      bus(1'b0, ad, 32'h0, d);
      chk(nm, d, exp);
   endtask : rd_chk

   // Reset values, an unmapped place, then events, mask and clearing.
   task automatic t_irq();
      rd_chk("status", 32'h0, 32'h0);
      rd_chk("mask", 32'h4, 32'h0);
      bus(1'b1, 32'h40, 32'hffff_ffff, d);
      rd_chk("unmapped", 32'h40, 32'h0);
      rd_chk("mask", 32'h4, 32'h0);
      cm.drive(16'h8000, 16'h8000, 12'h3de);
      cm.drive(16'h8000, 16'h8000, 12'h3fe);
      rd_chk("events", 32'h0, 32'h7);
      chk("irq_masked", 32'(irq), 32'h0);
      bus(1'b1, 32'h4, 32'h2, d);
      @(negedge clk_sys);
      chk("irq_on", 32'(irq), 32'h1);
      bus(1'b1, 32'h0, 32'h2, d);
      @(negedge clk_sys);
      chk("irq_off", 32'(irq), 32'h0);
      rd_chk("w1c", 32'h0, 32'h5);
      rd_chk("result", 32'h8, 32'(ref_alu(16'h8000, 16'h8000, 1'b0, 3'h3)));
   endtask : t_irq

   // Every code on pairs that reach carry, overflow and zero.
   task automatic t_funcs();
      logic [15:0] av [3];
      logic [15:0] bv [3];
      logic [20:0] m;
      logic [20:0] r;
      av = '{16'h8000, 16'h7fff, 16'h0f0f};
      bv = '{16'h8000, 16'h0001, 16'hf0f0};
      for (int i = 0; i < 3; i++)
         for (int f = 0; f < 8; f++)
         begin
            cm.drive(av[i], bv[i], {i[0], f[2:0], 8'hfe});
            @(negedge clk_sys);
            m = (f inside {1, 2, 3}) ? 21'h1fffff : 21'h08ffff;
            r = ref_alu(av[i], bv[i], i[0], f[2:0]) & m;
            chk("alu", 32'(obs & m), 32'(r));
         end
   endtask : t_funcs

   task automatic t_sub();
      for (int k = 0; k < 2; k++)
      begin
         cm.sub(16'h0005, 16'h0007, k[0]);
         @(negedge clk_sys);
         chk("diff", 32'(f_out), k[0] ? 32'hfffe : 32'h0002);
      end
   endtask : t_sub

   // Forced-zero operands, then accumulation through the result register.
   task automatic t_osel();
      logic [15:0] e;
      for (int k = 1; k < 4; k++)
      begin
         cm.drive(16'h0a0a, 16'h5050, {4'h3, 5'h1f, k[0], k[1], 1'b0});
         @(negedge clk_sys);
         e = (k == 1) ? 16'h0a0a : (k == 2) ? 16'h5050 : 16'h5a5a;
         chk("osel", 32'(f_out), 32'(e));
      end
      cm.drive(16'h0005, 16'h0, 12'h3dc);
      repeat (2) cm.drive(16'h0005, 16'h0, 12'h3d8);
      cm.drive(16'h0005, 16'h0, 12'h3f0);
      @(negedge clk_sys);
      chk("accum", 32'(f_out), 32'h000f);
   endtask : t_osel

   // Registered path, then bypasses while the operand registers keep loading.
   task automatic t_pipe();
      cm.drive(16'h1234, 16'h1111, 12'h326);
      cm.drive(16'hffff, 16'hffff, 12'h3c6);
      cm.drive(16'hffff, 16'hffff, 12'h3e7);
      @(negedge clk_sys);
      chk("f_reg", 32'({f_oe_n, f_out}), 32'h12345);
      cm.drive(16'h0001, 16'h0002, 12'h33f);
      @(negedge clk_sys);
      chk("ab_byp", 32'(f_out), 32'h0003);
      cm.drive(16'hffff, 16'hffff, 12'h3e6);
      @(negedge clk_sys);
      chk("f_kept", 32'(f_out), 32'h2345);
      cm.drive(16'hffff, 16'hffff, 12'h3ee);
      @(negedge clk_sys);
      chk("ab_loaded", 32'(f_out), 32'h0003);
   endtask : t_pipe

   task automatic wrap_up();
      if (miscompares == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : wrap_up

   // Main sequence after three cycles of reset.
   initial
   begin
      repeat (3) @(posedge clk_sys);
      reset <= 1'b0;
      t_irq();
      t_funcs();
      t_sub();
      t_osel();
      t_pipe();
      wrap_up();
   end

   // Watchdog: the run needs under a hundred cycles, so this is ample.
   initial
   begin
      #20000;
      miscompares++;
      wrap_up();
   end
endmodule : tb

bind alu_slice16 alu_monitor u_mon
(
   .CLK_SYS, .RESET, .A_IN, .B_IN, .CARRY_IN, .FUNCTION_SELECT, .EN_F_N,
   .OPERAND_BYPASS, .RESULT_BYPASS, .A_OPERAND_SELECT, .B_OPERAND_SELECT,
   .OE_N, .F_OUT, .F_OE_N, .CARRY_OUT, .PROPAGATE_N, .GENERATE_N,
   .OVERFLOW_FLAG, .ZERO_FLAG
);
